// ==== emergency_ramp_and_auto_mute.sv ====
// volume fall control and per-channel auto-silence for a stereo path
`timescale 1ns/1ps
module emergency_ramp_and_auto_mute (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic clock_fault,
  input wire logic power_fault,
  input wire logic soft_mute_req,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [silence_pkg::SAMPLE_W-1:0] in_left,
  input wire logic [silence_pkg::SAMPLE_W-1:0] in_right,
  output logic out_valid,
  input wire logic out_ready,
  output logic [silence_pkg::SAMPLE_W-1:0] out_left,
  output logic [silence_pkg::SAMPLE_W-1:0] out_right,
  output logic [7:0] volume,
  output logic left_silenced,
  output logic right_silenced
);
  import silence_pkg::*;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] normal_ramp_q, normal_ramp_d;
  logic [7:0] emerg_ramp_q, emerg_ramp_d;
  logic [7:0] sil_config_q, sil_config_d;
  logic [7:0] sil_delay_q, sil_delay_d;
  logic [7:0] vol_set_q, vol_set_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] vol_q;

  always_comb begin
    normal_ramp_d = normal_ramp_q;
    emerg_ramp_d = emerg_ramp_q;
    sil_config_d = sil_config_q;
    sil_delay_d = sil_delay_q;
    vol_set_d = vol_set_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_NORMAL_RAMP: normal_ramp_d = reg_wdata;
        ADDR_EMERG_RAMP: emerg_ramp_d = reg_wdata;
        ADDR_SIL_CONFIG: sil_config_d = reg_wdata;
        ADDR_SIL_DELAY: sil_delay_d = reg_wdata;
        ADDR_VOLUME: vol_set_d = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_NORMAL_RAMP: rdata_d = normal_ramp_q;
        ADDR_EMERG_RAMP: rdata_d = emerg_ramp_q;
        ADDR_SIL_CONFIG: rdata_d = sil_config_q;
        ADDR_SIL_DELAY: rdata_d = sil_delay_q;
        // reads back the live volume, not the setting
        ADDR_VOLUME: rdata_d = vol_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      normal_ramp_q <= RST_NORMAL_RAMP;
      emerg_ramp_q <= RST_EMERG_RAMP;
      sil_config_q <= RST_SIL_CONFIG;
      sil_delay_q <= RST_SIL_DELAY;
      vol_set_q <= RST_VOLUME;
      rdata_q <= 8'h00;
    end else begin
      normal_ramp_q <= normal_ramp_d;
      emerg_ramp_q <= emerg_ramp_d;
      sil_config_q <= sil_config_d;
      sil_delay_q <= sil_delay_d;
      vol_set_q <= vol_set_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // sample path
  // ---------------------------------------------------------------
  logic buf_valid;
  logic buf_ready;
  logic [2*SAMPLE_W-1:0] buf_data;
  logic sample_take;

  skid_buffer #(
    .W(2 * SAMPLE_W)
  ) u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_left, in_right}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // one sample period per pair leaving the buffer
  logic [SAMPLE_W-1:0] left_q, left_d, right_q, right_d;
  logic ovalid_q, ovalid_d;

  assign buf_ready = !ovalid_q || out_ready;
  assign sample_take = buf_valid && buf_ready;

  // ---------------------------------------------------------------
  // auto-silence
  // ---------------------------------------------------------------
  logic left_reached, right_reached;
  logic left_ok, right_ok;
  logic left_sil, right_sil;

  zero_run_counter u_left (
    .clk_sys(clk_sys),
    .srst(srst),
    .sample_take(sample_take),
    .sample(buf_data[2*SAMPLE_W-1:SAMPLE_W]),
    .delay_code(sil_delay_q[LDLY_HI:LDLY_LO]),
    .reached(left_reached)
  );

  zero_run_counter u_right (
    .clk_sys(clk_sys),
    .srst(srst),
    .sample_take(sample_take),
    .sample(buf_data[SAMPLE_W-1:0]),
    .delay_code(sil_delay_q[RDLY_HI:RDLY_LO]),
    .reached(right_reached)
  );

  assign left_ok = left_reached && sil_config_q[CFG_LEFT_EN];
  assign right_ok = right_reached && sil_config_q[CFG_RIGHT_EN];

  // joint mode waits for both; a disabled channel therefore blocks both
  always_comb begin
    if (sil_config_q[CFG_JOINT]) begin
      left_sil = left_ok && right_ok;
      right_sil = left_ok && right_ok;
    end else begin
      left_sil = left_ok;
      right_sil = right_ok;
    end
  end

  assign left_silenced = left_sil;
  assign right_silenced = right_sil;

  always_comb begin
    ovalid_d = ovalid_q;
    left_d = left_q;
    right_d = right_q;
    if (sample_take) begin
      ovalid_d = 1'b1;
      left_d = left_sil ? '0 : buf_data[2*SAMPLE_W-1:SAMPLE_W];
      right_d = right_sil ? '0 : buf_data[SAMPLE_W-1:0];
    end else if (out_ready) begin
      ovalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ovalid_q <= 1'b0;
      left_q <= '0;
      right_q <= '0;
    end else begin
      ovalid_q <= ovalid_d;
      left_q <= left_d;
      right_q <= right_d;
    end
  end

  assign out_valid = ovalid_q;
  assign out_left = left_q;
  assign out_right = right_q;

  // ---------------------------------------------------------------
  // volume fall sequencer
  // ---------------------------------------------------------------
  fall_state_t st_q, st_d;
  logic [7:0] vol_d;
  logic [1:0] per_q, per_d;
  logic emerg_q, emerg_d;
  logic fault;
  logic [1:0] iv_code, st_code;
  logic [1:0] per_lim;
  logic [3:0] step;
  logic [8:0] vol_sum;

  assign fault = clock_fault || power_fault;
  // a fault, once latched in emerg_q, picks emergency fields until the hold is left or the next fall starts; otherwise the normal ones
  assign iv_code = emerg_q ? emerg_ramp_q[FALL_IV_HI:FALL_IV_LO]
                           : normal_ramp_q[FALL_IV_HI:FALL_IV_LO];
  assign st_code = emerg_q ? emerg_ramp_q[FALL_ST_HI:FALL_ST_LO]
                           : normal_ramp_q[FALL_ST_HI:FALL_ST_LO];

  always_comb begin
    case (iv_code)
      2'h0: per_lim = 2'h0;
      2'h1: per_lim = 2'h1;
      default: per_lim = 2'h3;
    endcase
    // volume code is 0.5 dB per count
    case (st_code)
      2'h0: step = 4'h8;
      2'h1: step = 4'h4;
      2'h2: step = 4'h2;
      default: step = 4'h1;
    endcase
  end

  assign vol_sum = {1'b0, vol_q} + {5'h00, step};

  always_comb begin
    st_d = st_q;
    vol_d = vol_q;
    per_d = per_q;
    emerg_d = emerg_q;
    case (st_q)
      ST_IDLE: begin
        vol_d = vol_set_q;
        per_d = 2'h0;
        if (fault || soft_mute_req) begin
          st_d = ST_FALL;
          emerg_d = fault;
        end
      end
      ST_FALL: begin
        // a fault during a soft fall switches to emergency pacing
        if (fault) begin
          emerg_d = 1'b1;
        end
        if (!fault && !soft_mute_req) begin
          st_d = ST_IDLE;
        end else if (iv_code == IV_INSTANT) begin
          vol_d = VOL_MUTE;
          st_d = ST_HOLD;
        end else if (sample_take) begin
          if (per_q == per_lim) begin
            per_d = 2'h0;
            if (vol_sum >= {1'b0, VOL_MUTE}) begin
              vol_d = VOL_MUTE;
              st_d = ST_HOLD;
            end else begin
              vol_d = vol_sum[7:0];
            end
          end else begin
            per_d = per_q + 2'h1;
          end
        end
      end
      ST_HOLD: begin
        vol_d = VOL_MUTE;
        if (!fault && !soft_mute_req) begin
          st_d = ST_IDLE;
          emerg_d = 1'b0;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ST_IDLE;
      vol_q <= RST_VOLUME;
      per_q <= 2'h0;
      emerg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      vol_q <= vol_d;
      per_q <= per_d;
      emerg_q <= emerg_d;
    end
  end

  assign volume = vol_q;
endmodule

// ==== silence_pkg.sv ====
// shared constants for emergency ramp and auto-silence control
package silence_pkg;
  localparam logic [7:0] ADDR_NORMAL_RAMP = 8'h4e;
  localparam logic [7:0] ADDR_EMERG_RAMP = 8'h4f;
  localparam logic [7:0] ADDR_SIL_CONFIG = 8'h50;
  localparam logic [7:0] ADDR_SIL_DELAY = 8'h51;
  localparam logic [7:0] ADDR_VOLUME = 8'h4c;
  localparam logic [7:0] RST_NORMAL_RAMP = 8'h33;
  localparam logic [7:0] RST_EMERG_RAMP = 8'h30;
  localparam logic [7:0] RST_SIL_CONFIG = 8'h07;
  localparam logic [7:0] RST_SIL_DELAY = 8'h00;
  localparam logic [7:0] RST_VOLUME = 8'h30;
  localparam logic [7:0] VOL_MUTE = 8'hff;
  localparam int FALL_IV_HI = 7;
  localparam int FALL_IV_LO = 6;
  localparam int FALL_ST_HI = 5;
  localparam int FALL_ST_LO = 4;
  localparam int CFG_LEFT_EN = 0;
  localparam int CFG_RIGHT_EN = 1;
  localparam int CFG_JOINT = 2;
  localparam int LDLY_HI = 6;
  localparam int LDLY_LO = 4;
  localparam int RDLY_HI = 2;
  localparam int RDLY_LO = 0;
  localparam logic [1:0] IV_INSTANT = 2'h3;
  // reference sample rate for the delay codes
  localparam int REF_RATE_HZ = 96000;
  // delay figures in microseconds at the reference rate
  localparam int DLY_US_0 = 11500;
  localparam int DLY_US_1 = 53000;
  localparam int DLY_US_2 = 106500;
  localparam int DLY_US_3 = 320000;
  localparam int DLY_US_4 = 535000;
  localparam int DLY_US_5 = 1065000;
  localparam int DLY_US_6 = 2665000;
  localparam int DLY_US_7 = 5330000;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] ZCNT_0 = CNT_W'(DLY_US_0 * 96 / 1000);
  localparam logic [CNT_W-1:0] ZCNT_1 = CNT_W'(DLY_US_1 * 96 / 1000);
  localparam logic [CNT_W-1:0] ZCNT_2 = CNT_W'(DLY_US_2 * 96 / 1000);
  localparam logic [CNT_W-1:0] ZCNT_3 = CNT_W'(DLY_US_3 * 96 / 1000);
  localparam logic [CNT_W-1:0] ZCNT_4 = CNT_W'(DLY_US_4 * 96 / 1000);
  localparam logic [CNT_W-1:0] ZCNT_5 = CNT_W'(DLY_US_5 * 96 / 1000);
  localparam logic [CNT_W-1:0] ZCNT_6 = CNT_W'(DLY_US_6 * 96 / 1000);
  localparam logic [CNT_W-1:0] ZCNT_7 = CNT_W'(64'(DLY_US_7) * 96 / 1000);
  localparam int SAMPLE_W = 24;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FALL = 3'b010,
    ST_HOLD = 3'b100
  } fall_state_t;
endpackage

// ==== zero_run_counter.sv ====
// per-channel run-of-zero-samples counter
`timescale 1ns/1ps
module zero_run_counter (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sample_take,
  input wire logic [silence_pkg::SAMPLE_W-1:0] sample,
  input wire logic [2:0] delay_code,
  output logic reached
);
  import silence_pkg::*;

  logic [CNT_W-1:0] cnt_q, cnt_d, limit;
  logic reached_q, reached_d;

  always_comb begin
    case (delay_code)
      3'h0: limit = ZCNT_0;
      3'h1: limit = ZCNT_1;
      3'h2: limit = ZCNT_2;
      3'h3: limit = ZCNT_3; // code 3, decoded like the others to the DLY_US_3 count
      3'h4: limit = ZCNT_4;
      3'h5: limit = ZCNT_5;
      3'h6: limit = ZCNT_6;
      default: limit = ZCNT_7;
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    if (sample_take) begin
      if (sample != '0) begin
        cnt_d = '0;
      end else if (cnt_q < limit) begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
    // shrinking the delay code takes effect at once
    reached_d = (cnt_d >= limit);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q <= '0;
      reached_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      reached_q <= reached_d;
    end
  end

  assign reached = reached_q;
endmodule

// ==== skid_buffer.sv ====
// two-entry valid/ready buffer for stereo sample pairs
`timescale 1ns/1ps
module skid_buffer #(
  parameter int W = 48
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic rd_q, rd_d, wr_q, wr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    rd_d = rd_q;
    wr_d = wr_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// ==== emergency_ramp_and_auto_mute_monitor.sv ====
// port checker for emergency ramp and auto-silence
`timescale 1ns/1ps
module emergency_ramp_and_auto_mute_monitor
  import silence_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic clock_fault,
  input wire logic power_fault,
  input wire logic soft_mute_req,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [silence_pkg::SAMPLE_W-1:0] in_left,
  input wire logic [silence_pkg::SAMPLE_W-1:0] in_right,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [silence_pkg::SAMPLE_W-1:0] out_left,
  input wire logic [silence_pkg::SAMPLE_W-1:0] out_right,
  input wire logic [7:0] volume,
  input wire logic left_silenced,
  input wire logic right_silenced
);
  // ----------------------------------------
  // shadow of the registers we judge against
  // ----------------------------------------
  logic [7:0] emerg_q, emerg_d, cfg_q, cfg_d;
  logic fault;
  assign fault = clock_fault || power_fault;
  always_comb begin
    emerg_d = emerg_q;
    cfg_d = cfg_q;
    if (reg_wr && reg_addr == ADDR_EMERG_RAMP) begin
      emerg_d = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_SIL_CONFIG) begin
      cfg_d = reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      emerg_q <= RST_EMERG_RAMP;
      cfg_q <= RST_SIL_CONFIG;
    end else begin
      emerg_q <= emerg_d;
      cfg_q <= cfg_d;
    end
  end
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_cfg_readback: assert property (reg_rd && reg_addr == ADDR_SIL_CONFIG |=> reg_rdata == $past(cfg_q))
    else $error("config readback wrong");
  a_instant_mute: assert property (fault && emerg_q[7:6] == IV_INSTANT |-> ##[0:2] volume == VOL_MUTE)
    else $error("instant mute not applied");
  // two cycles of fault first, so a soft step still in flight is not judged
  a_emerg_step: assert property (fault && $past(fault) && $past(fault, 2) && emerg_q[7:6] != IV_INSTANT
    && $stable(emerg_q) |-> volume == $past(volume) || volume == VOL_MUTE
    || volume == $past(volume) + (8'h08 >> emerg_q[5:4])) else $error("emergency step size wrong");
  a_fault_falls: assert property (fault && $past(fault) |-> volume >= $past(volume))
    else $error("volume rose during fault");
  a_left_gate: assert property (!cfg_q[CFG_LEFT_EN] |-> !left_silenced)
    else $error("left silenced while disabled");
  a_right_gate: assert property (!cfg_q[CFG_RIGHT_EN] |-> !right_silenced)
    else $error("right silenced while disabled");
  a_joint_pair: assert property (cfg_q[CFG_JOINT] |-> left_silenced == right_silenced)
    else $error("joint silence split");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_left) && $stable(out_right))
    else $error("output pair changed while stalled");
  c_instant: cover property (fault && volume == VOL_MUTE);
  c_left_only: cover property (left_silenced && !right_silenced);
  c_joint: cover property (left_silenced && right_silenced && cfg_q[CFG_JOINT]);
endmodule

bind emergency_ramp_and_auto_mute emergency_ramp_and_auto_mute_monitor i_mon (.clk_sys, .srst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clock_fault, .power_fault, .soft_mute_req, .in_valid, .in_ready,
  .in_left, .in_right, .out_valid, .out_ready, .out_left, .out_right, .volume, .left_silenced, .right_silenced);

// ==== emergency_ramp_and_auto_mute_tb_top.sv ====
// self-checking bench for emergency ramp and auto-silence
`timescale 1ns/1ps
module emergency_ramp_and_auto_mute_tb_top;
  import silence_pkg::*;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic clock_fault = 1'h0;
  logic power_fault = 1'h0;
  logic soft_mute_req = 1'h0;
  logic in_valid = 1'h0;
  logic out_ready = 1'h1;
  logic [SAMPLE_W-1:0] in_left = 24'h000000;
  logic [SAMPLE_W-1:0] in_right = 24'h000000;
  logic [7:0] reg_rdata, volume;
  logic in_ready, out_valid, left_silenced, right_silenced;
  logic [SAMPLE_W-1:0] out_left, out_right;
  int mismatches = 0;
  int checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  emergency_ramp_and_auto_mute i_dut (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .clock_fault, .power_fault, .soft_mute_req, .in_valid, .in_ready, .in_left, .in_right, .out_valid,
    .out_ready, .out_left, .out_right, .volume, .left_silenced, .right_silenced);
  // ----------------------------------------
  // bus, stream and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one past the edge so registered outputs have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    chk(24'(reg_rdata), 24'(e));
  endtask
  task automatic push(input logic [23:0] l, input logic [23:0] r, input int n);
    int k;
    logic ok;
    k = 0;
    @(posedge clk_sys);
    in_left <= l;
    in_right <= r;
    in_valid <= 1'h1;
    while (k < n) begin
      @(negedge clk_sys);
      ok = in_ready;
      @(posedge clk_sys);
      if (ok === 1'h1) k++;
    end
    in_valid <= 1'h0;
    wait_cyc(4);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(ADDR_EMERG_RAMP, 8'h30);
    rd(ADDR_SIL_CONFIG, 8'h07);
    rd(ADDR_SIL_DELAY, 8'h00);
    wr(8'h60, 8'hff);
    rd(8'h60, 8'h00);
    wr(ADDR_SIL_DELAY, 8'h5a);
    rd(ADDR_SIL_DELAY, 8'h5a);
    wr(ADDR_SIL_DELAY, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_emerg();
    logic [7:0] code [4] = '{8'h00, 8'h50, 8'ha0, 8'h30};
    logic [7:0] want [4] = '{8'h70, 8'h40, 8'h34, 8'h38};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_EMERG_RAMP, code[i]);
      if (i == 3) power_fault <= 1'h1;
      else clock_fault <= 1'h1;
      push(24'h000111, 24'h000222, 8);
      chk(24'(volume), 24'(want[i]));
      clock_fault <= 1'h0;
      power_fault <= 1'h0;
      wait_cyc(4);
      chk(24'(volume), 24'h000030);
    end
    wr(ADDR_EMERG_RAMP, 8'hc0);
    clock_fault <= 1'h1;
    wait_cyc(3);
    chk(24'(volume), 24'h0000ff);
    clock_fault <= 1'h0;
    wait_cyc(4);
    $display("test emerg done");
  endtask
  // normal settings give one count per sample, emergency eight
  task automatic t_soft();
    wr(ADDR_EMERG_RAMP, 8'h00);
    soft_mute_req <= 1'h1;
    push(24'h000111, 24'h000222, 4);
    chk(24'(volume), 24'h000034);
    clock_fault <= 1'h1;
    push(24'h000111, 24'h000222, 4);
    chk(24'(volume), 24'h000054);
    soft_mute_req <= 1'h0;
    clock_fault <= 1'h0;
    wait_cyc(4);
    chk(24'(volume), 24'h000030);
    $display("test soft done");
  endtask
  task automatic t_silence();
    wr(ADDR_SIL_CONFIG, 8'h03);
    push(24'h000000, 24'h000001, int'(ZCNT_0) - 1);
    chk(24'({left_silenced, right_silenced}), 24'h000000);
    push(24'h000000, 24'h000001, 1);
    chk(24'({left_silenced, right_silenced}), 24'h000002);
    chk(out_left, 24'h000000);
    chk(out_right, 24'h000001);
    wr(ADDR_SIL_CONFIG, 8'h07);
    wait_cyc(1);
    chk(24'(left_silenced), 24'h000000);
    wr(ADDR_SIL_CONFIG, 8'h02);
    wait_cyc(1);
    chk(24'(left_silenced), 24'h000000);
    wr(ADDR_SIL_CONFIG, 8'h07);
    push(24'h000000, 24'h000000, int'(ZCNT_0));
    chk(24'({left_silenced, right_silenced}), 24'h000003);
    wr(ADDR_SIL_CONFIG, 8'h01);
    wait_cyc(1);
    chk(24'({left_silenced, right_silenced}), 24'h000002);
    wr(ADDR_SIL_DELAY, 8'h01);
    push(24'h000001, 24'h000001, 1);
    wr(ADDR_SIL_CONFIG, 8'h03);
    push(24'h000000, 24'h000000, int'(ZCNT_1) - 1);
    chk(24'({left_silenced, right_silenced}), 24'h000002);
    push(24'h000000, 24'h000000, 1);
    chk(24'({left_silenced, right_silenced}), 24'h000003);
    wr(ADDR_SIL_DELAY, 8'h03);
    push(24'h000001, 24'h000001, 1);
    push(24'h000000, 24'h000000, int'(ZCNT_3) - 1);
    chk(24'({left_silenced, right_silenced}), 24'h000002);
    push(24'h000000, 24'h000000, 1);
    chk(24'({left_silenced, right_silenced}), 24'h000003);
    wr(ADDR_SIL_CONFIG, 8'h00);
    $display("test silence done");
  endtask
  // receiver stalls until the buffer refuses, then drains in order
  task automatic t_buf();
    int acc;
    int got;
    logic ok;
    acc = 0;
    got = 0;
    @(posedge clk_sys);
    out_ready <= 1'h0;
    in_valid <= 1'h1;
    in_left <= 24'h000100;
    in_right <= 24'h000200;
    repeat (6) begin
      @(negedge clk_sys);
      ok = in_ready;
      @(posedge clk_sys);
      if (ok === 1'h1) begin
        acc++;
        in_left <= 24'h000100 + 24'(acc);
      end
    end
    in_valid <= 1'h0;
    wait_cyc(1);
    chk(24'(in_ready), 24'h000000);
    out_ready <= 1'h1;
    repeat (8) begin
      @(negedge clk_sys);
      if (out_valid === 1'h1) begin
        chk(out_left, 24'h000100 + 24'(got));
        got++;
      end
    end
    chk(24'(got), 24'(acc));
    $display("test buf done");
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'h0;
    t_regs();
    t_emerg();
    t_soft();
    t_silence();
    t_buf();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
endmodule
